// File: hw/adc_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// host for the serial converter: starts conversions, waits busy, reads 16 bits
module adc_host_ctrl
  import adc_host_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // user request
  input wire logic i_start,
  input wire logic i_sleep_mode,
  input wire logic i_select,
  output logic o_ready,
  output logic [RESULT_BITS-1:0] o_result,
  output logic o_result_valid,
  // converter pins
  output logic o_conversion_start_n,
  output logic o_serial_clock,
  input wire logic i_serial_data_out,
  input wire logic i_busy
);
  // the shared timer must hold the longest wait, the bit counter a whole word
  if (WAKE_CYC >= (1 << TMR_W) || WORD_BITS >= (1 << BIT_CNT_W))
  begin
    $error("counter too narrow");
  end
  logic busy_m_q;
  logic busy_s_q;
  logic sdo_m_q;
  logic sdo_s_q;
  logic busy_old_q;
  // two-flop synchronisers on the pins from the converter
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      busy_m_q <= 1'b0;
      busy_s_q <= 1'b0;
      sdo_m_q <= 1'b0;
      sdo_s_q <= 1'b0;
      busy_old_q <= 1'b0;
    end
    else
    begin
      busy_m_q <= i_busy;
      busy_s_q <= busy_m_q;
      sdo_m_q <= i_serial_data_out;
      sdo_s_q <= sdo_m_q;
      busy_old_q <= busy_s_q;
    end
  end
  logic busy_fall;
  assign busy_fall = busy_old_q & ~busy_s_q;
  host_state_type state_q;
  host_state_type state_d;
  logic [TMR_W-1:0] tmr_q;
  logic [TMR_W-1:0] tmr_d;
  logic [BIT_CNT_W-1:0] bits_q;
  logic [BIT_CNT_W-1:0] bits_d;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] shift_d;
  logic cs_n_q;
  logic cs_n_d;
  logic sleep_q;
  logic sleep_d;
  logic [RESULT_BITS-1:0] res_q;
  logic [RESULT_BITS-1:0] res_d;
  logic valid_q;
  logic valid_d;
  logic run;
  logic sclk;
  logic sclk_rise;
  logic sclk_fall;
  adc_sclk_gen #(
    .HALF_CYC(SCLK_HALF_CYC)
  ) u_sclk (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(run),
    .o_sclk(sclk),
    .o_rise(sclk_rise),
    .o_fall(sclk_fall)
  );
  // serial clock runs only while reading, at most 16 periods
  assign run = (state_q == ST_READ) && (bits_q < BIT_CNT_W'(WORD_BITS));
  // select gates the clock; the gate stays low when the part is not chosen
  assign o_serial_clock = sclk & i_select;
  // sequence control
  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q;
    bits_d = bits_q;
    shift_d = shift_q;
    cs_n_d = cs_n_q;
    sleep_d = sleep_q;
    res_d = res_q;
    valid_d = 1'b0;
    case (state_q)
      ST_IDLE:
      begin
        if (i_start)
        begin
          sleep_d = i_sleep_mode;
          tmr_d = '0;
          cs_n_d = 1'b1;
          // auto-sleep: raise start to wake, wait before the hold edge
          state_d = i_sleep_mode ? ST_WAKE : ST_START;
        end
      end
      ST_WAKE:
      begin
        // high for the full wake time (WAKE_CYC cycles) so hold follows our falling edge, not the wake timer
        if (tmr_q == TMR_W'(WAKE_CYC - 1))
        begin
          tmr_d = '0;
          cs_n_d = 1'b0;
          state_d = ST_BUSY;
        end
        else
          tmr_d = tmr_q + 1'b1;
      end
      ST_START:
      begin
        // falling edge with serial clock low starts conversion and resets counter
        cs_n_d = 1'b0;
        if (tmr_q == TMR_W'(START_LOW_CYC - 1))
        begin
          tmr_d = '0;
          cs_n_d = 1'b1;
          state_d = ST_BUSY;
        end
        else
          tmr_d = tmr_q + 1'b1;
      end
      ST_BUSY:
      begin
        // in sleep mode start stays low across end of conversion
        if (busy_fall)
        begin
          bits_d = '0;
          shift_d = '0;
          state_d = ST_READ;
        end
      end
      ST_READ:
      begin
        // sample on the rising edge: bit is stable there (changes on fall)
        if (sclk_rise)
        begin
          shift_d = {shift_q[WORD_BITS-2:0], sdo_s_q};
          bits_d = bits_q + 1'b1;
        end
        // close on the sixteenth falling edge so the line is low as we leave
        if (bits_q == BIT_CNT_W'(WORD_BITS) && sclk_fall)
        begin
          res_d = shift_q[RESULT_BITS-1:0];
          valid_d = 1'b1;
          tmr_d = '0;
          state_d = ST_GAP;
        end
      end
      ST_GAP:
      begin
        // settle time before any further start edge
        if (tmr_q == TMR_W'(READ_GAP_CYC - 1))
        begin
          tmr_d = '0;
          state_d = ST_IDLE;
        end
        else
          tmr_d = tmr_q + 1'b1;
      end
      default:
        state_d = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      bits_q <= '0;
      shift_q <= '0;
      cs_n_q <= 1'b1;
      sleep_q <= 1'b0;
      res_q <= '0;
      valid_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      cs_n_q <= cs_n_d;
      sleep_q <= sleep_d;
      res_q <= res_d;
      valid_q <= valid_d;
    end
  end
  assign o_conversion_start_n = cs_n_q;
  assign o_result = res_q;
  assign o_result_valid = valid_q;
  assign o_ready = (state_q == ST_IDLE);
  // checks
  property p_clk_low_at_start;
    @(posedge i_sys_clk) disable iff (i_rst)
      $fell(cs_n_q) |-> !sclk;
  endproperty
  a_clk_low_at_start: assert property (p_clk_low_at_start)
    else $error("serial clock high at start fall");
  property p_no_clk_outside_read;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q != ST_READ) |-> !sclk;
  endproperty
  a_no_clk_outside_read: assert property (p_no_clk_outside_read)
    else $error("serial clock outside read");
  property p_sixteen;
    @(posedge i_sys_clk) disable iff (i_rst)
      sclk_rise |-> bits_q < BIT_CNT_W'(WORD_BITS);
  endproperty
  a_sixteen: assert property (p_sixteen)
    else $error("more than 16 clocks");
  localparam int GAP_LAST = int'(READ_GAP_CYC) - 1;
  property p_gap;
    @(posedge i_sys_clk) disable iff (i_rst)
      $rose(state_q == ST_GAP) |-> ##GAP_LAST (state_q == ST_GAP);
  endproperty
  a_gap: assert property (p_gap)
    else $error("start too soon after read");
  property p_start_pulse;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == ST_IDLE && i_start && !i_sleep_mode) |-> ##2 !cs_n_q;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start did not fall");
  property p_sleep_low;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == ST_BUSY && sleep_q) |-> !cs_n_q;
  endproperty
  a_sleep_low: assert property (p_sleep_low)
    else $error("start not low in sleep conversion");
  property p_fast_high;
    @(posedge i_sys_clk) disable iff (i_rst)
      (state_q == ST_BUSY && !sleep_q) |-> cs_n_q;
  endproperty
  a_fast_high: assert property (p_fast_high)
    else $error("start not high in fast conversion");
  property p_valid;
    @(posedge i_sys_clk) disable iff (i_rst)
      valid_q |-> state_q == ST_GAP;
  endproperty
  a_valid: assert property (p_valid)
    else $error("result strobe out of place");
  property p_result_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
      !valid_q |-> $stable(res_q);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without strobe");
  c_fast: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    valid_q && !sleep_q);
  c_sleep: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    valid_q && sleep_q);
  c_read: cover property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(state_q == ST_READ));
endmodule
`default_nettype wire

// File: hw/adc_host_pkg.sv
// Behaviour
// - read is exactly 16 serial clocks
// - read ends 400 ns before next start
// - start high at end selects high-rate
// - start low at end selects auto-sleep
// - serial clock low after sixteenth bit
// - no start fall during read, clock low
// - bytes allowed with clock low between them
// - serial clock at most 10 MHz
// - host sources the serial clock
// - host detects end of conversion from busy
// - serial clock gated by active-high select
package adc_host_pkg;
  localparam int unsigned SYS_CLK_PERIOD_PS = 4000;
  localparam int unsigned READ_GAP_NS = 400;
  localparam int unsigned WAKE_US = 6;
  localparam int unsigned CONV_US = 8;
  localparam int unsigned SCLK_MAX_KHZ = 10000;
  // serial clock half period, rounded up so the rate never exceeds the limit
  localparam int unsigned SCLK_HALF_CYC =
    (1000000000 / SCLK_MAX_KHZ / 2 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int unsigned READ_GAP_CYC =
    (READ_GAP_NS * 1000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int unsigned WAKE_CYC =
    (WAKE_US * 1000000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int unsigned CONV_CYC =
    (CONV_US * 1000000 + SYS_CLK_PERIOD_PS - 1) / SYS_CLK_PERIOD_PS;
  localparam int unsigned START_LOW_CYC = 8;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned RESULT_BITS = 12;
  localparam int unsigned BIT_CNT_W = 5;
  localparam int unsigned TMR_W = 14;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE = 3'b001,
    ST_START = 3'b010,
    ST_BUSY = 3'b011,
    ST_READ = 3'b100,
    ST_GAP = 3'b101
  } host_state_type;
endpackage

// File: hw/adc_sclk_gen.sv
`timescale 1ns/1ps
`default_nettype none
// serial clock divider; emits low-high-low periods while run is high, finishing any started period
module adc_sclk_gen
  import adc_host_pkg::*;
#(
  parameter int unsigned HALF_CYC = SCLK_HALF_CYC
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // control
  input wire logic i_run,
  // outputs
  output logic o_sclk,
  output logic o_rise,
  output logic o_fall
);
  // the 8-bit counter cannot serve a longer half period
  if (HALF_CYC < 1 || HALF_CYC > 255)
  begin
    $error("half period out of range");
  end
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic sclk_q;
  logic sclk_d;
  // toggle at each half period; idle stays low between words
  always_comb
  begin
    cnt_d = cnt_q;
    sclk_d = sclk_q;
    o_rise = 1'b0;
    o_fall = 1'b0;
    if (i_run || sclk_q)
    begin
      if (cnt_q == 8'(HALF_CYC - 1))
      begin
        cnt_d = 8'h00;
        sclk_d = ~sclk_q;
        o_rise = ~sclk_q;
        o_fall = sclk_q;
      end
      else
        cnt_d = cnt_q + 8'h01;
    end
  end
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 8'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      sclk_q <= sclk_d;
    end
  end
  assign o_sclk = sclk_q;
endmodule
`default_nettype wire

// File: verification/adc_device_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural converter: hold on start fall, busy while converting, 16-bit serial word
module adc_device_model #(
  parameter real CONV_NS = 7800.0,
  parameter real WAKE_NS = 6000.0,
  parameter real ACCESS_NS = 20.0,
  parameter real HOLD_NS = 10.0
)
(
  // converter pins
  input wire logic i_conversion_start_n,
  input wire logic i_serial_clock,
  output logic o_serial_data_out,
  output logic o_busy,
  // analog stand-in
  input wire logic [11:0] i_sample
);
  logic [15:0] word_q = 16'h0000;
  logic asleep = 1'b0;
  int edges = 0;
  realtime t_wake = 0.0;

  initial
  begin
    o_busy = 1'b0;
    o_serial_data_out = 1'b1;
  end

  // a wake still running delays the hold; starts during a conversion are ignored
  always @(negedge i_conversion_start_n)
  begin
    if (!i_serial_clock)
      edges = 0;
    o_busy = 1'b1;
    if (asleep && ($realtime - t_wake < WAKE_NS))
      #(WAKE_NS - ($realtime - t_wake));
    #(CONV_NS);
    word_q = {4'h0, i_sample};
    o_busy = 1'b0;
    asleep = !i_conversion_start_n;
  end

  // wake begins on the rising start edge only when asleep
  always @(posedge i_conversion_start_n)
    if (asleep)
      t_wake = $realtime;

  // the first zero leaves on the rising edge, ahead of the other bits
  always @(posedge i_serial_clock)
    if (edges % 16 == 0)
      o_serial_data_out <= #(ACCESS_NS) word_q[15];

  // no pull on the line: a released line shows the inverse of its last bit
  always @(negedge i_serial_clock)
  begin
    edges = edges + 1;
    if (edges == 16)
      o_serial_data_out <= #(HOLD_NS) ~o_serial_data_out;
    else if (edges % 16 != 0)
      o_serial_data_out <= #(ACCESS_NS) word_q[15 - (edges % 16)];
  end
endmodule
`default_nettype wire

// File: verification/adc_host_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
// drives the host controller against the converter model
module adc_host_ctrl_bench;
  import adc_host_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic sleep_mode = 1'b0;
  logic select = 1'b1;
  logic ready, result_valid, start_n, sclk, serial_data_out, busy;
  logic [11:0] result;
  logic [11:0] sample = 12'h000;
  int err_count = 0;
  int checked = 0;
  int rises = 0;
  realtime t_fall = 0.0;
  realtime t_rise = 0.0;
  realtime t_sclk = 0.0;

  adc_host_ctrl i_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_start(start),
    .i_sleep_mode(sleep_mode), .i_select(select), .o_ready(ready), .o_result(result),
    .o_result_valid(result_valid), .o_conversion_start_n(start_n),
    .o_serial_clock(sclk), .i_serial_data_out(serial_data_out), .i_busy(busy));
  adc_device_model i_dev (.i_conversion_start_n(start_n), .i_serial_clock(sclk),
    .o_serial_data_out(serial_data_out), .o_busy(busy), .i_sample(sample));

  initial
    forever #2 sys_clk = ~sys_clk;

  task tally_and_finish;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s", $realtime, what);
    end
  endtask

  task automatic chk_time(input realtime got, input realtime min, input string what);
    checked++;
    if (got < min)
    begin
      err_count++;
      $display("CHECK FAILED %0t %s", $realtime, what);
    end
  endtask

  // bounded wait for the result pulse or for ready
  task automatic wait_for(input logic want_valid);
    int n;
    n = 0;
    while ((want_valid ? result_valid : ready) !== 1'b1 && n < 20000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20000)
    begin
      err_count++;
      $display("CHECK FAILED %0t timeout", $realtime);
      tally_and_finish();
    end
  endtask

  // the serial clock only runs once busy has fallen
  always @(posedge sclk)
  begin
    if (rises != 0)
      chk_time($realtime - t_sclk, 100.0, "serial clock too fast");
    t_sclk = $realtime;
    rises++;
    chk_bits({15'h0000, busy}, 16'h0000, "clock during conversion");
  end

  always @(negedge sclk)
    t_fall = $realtime;

  always @(posedge start_n)
    t_rise = $realtime;

  // each start fall closes a frame: clock low, whole word, settle gap
  always @(negedge start_n)
  begin
    chk_bits({15'h0000, sclk}, 16'h0000, "clock high at start");
    if (sleep_mode)
      chk_time($realtime - t_rise, 6000.0, "short wake");
    if (rises != 0)
    begin
      chk_bits(16'(rises), 16'h0010, "clock count");
      chk_time($realtime - t_fall, 400.0, "settle gap");
    end
    rises = 0;
  end

  // one conversion and read; sel low leaves the converter deselected
  task automatic convert(input logic mode, input logic sel, input logic [11:0] value);
    @(posedge sys_clk);
    sample <= value;
    sleep_mode <= mode;
    select <= sel;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    wait_for(1'b1);
    if (sel)
      chk_bits({4'h0, result}, {4'h0, value}, "result");
    else
      chk_bits(16'(rises), 16'h0000, "gated clock");
    chk_bits({15'h0000, start_n}, {15'h0000, ~mode}, "start level at end");
    wait_for(1'b0);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    convert(1'b0, 1'b1, 12'ha5c);
    convert(1'b0, 1'b1, 12'h3f1);
    convert(1'b0, 1'b0, 12'h555);
    convert(1'b0, 1'b1, 12'h0f0);
    convert(1'b1, 1'b1, 12'h800);
    convert(1'b1, 1'b1, 12'h001);
    convert(1'b1, 1'b1, 12'hfff);
    tally_and_finish();
  end
endmodule
`default_nettype wire
